/* design/rsx_pkg.sv */
// Purpose: Constants and opcode enumeration for the rotate/subtract/xor/sleep unit
// Assumes: 8-bit data path, 7-bit file addresses
// Notes:   Shared by the execution unit
package rsx_pkg;

   // ==========================================================
   // Operation selector
   typedef enum logic [3:0] {
      RSX_OP_NONE        = 4'h0,
      RSX_OP_ROT_RIGHT   = 4'h1,
      RSX_OP_LIT_SUB     = 4'h2,
      RSX_OP_REG_SUB     = 4'h3,
      RSX_OP_REG_SUB_BRW = 4'h4,
      RSX_OP_NIB_SWAP    = 4'h5,
      RSX_OP_XOR_LIT     = 4'h6,
      RSX_OP_XOR_REG     = 4'h7,
      RSX_OP_DIR_LOAD    = 4'h8,
      RSX_OP_SLEEP       = 4'h9
   } rsx_op_t;

   // ==========================================================
   // Run state
   typedef enum logic [0:0] {
      RSX_ST_RUN   = 1'b0,
      RSX_ST_SLEEP = 1'b1
   } rsx_state_t;

   // ==========================================================
   // Operand values and reset values
   localparam logic [6:0] RSX_MAX_FILE_ADDR = 7'h7f;
   localparam logic [2:0] RSX_DIR_SEL_A     = 3'h5;
   localparam logic [2:0] RSX_DIR_SEL_B     = 3'h6;
   localparam logic [2:0] RSX_DIR_SEL_C     = 3'h7;
   localparam logic       RSX_DEST_ACC      = 1'b0;
   localparam logic       RSX_DEST_FILE     = 1'b1;
   localparam logic [7:0] RSX_DIR_RESET     = 8'hff;
   localparam logic [7:0] RSX_ACC_RESET     = 8'h00;
   localparam logic [7:0] RSX_WDT_CLEARED   = 8'h00;
   localparam logic       RSX_TO_RESET      = 1'b1;
   localparam logic       RSX_PD_RESET      = 1'b1;
   localparam logic       RSX_FLAG_RESET    = 1'b0;

endpackage : rsx_pkg

/* design/rsx_exec.sv */
// Purpose: One-cycle execution of a slice of the instruction set
// Assumes: File read data is combinational for file_addr; inputs synchronous to clk
// Notes:   Sleep is left by the wake input
`timescale 1ns/1ps
module rsx_exec
   import rsx_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       exec_valid,
   input  wire rsx_op_t    exec_op,
   input  wire logic [6:0] file_addr,
   input  wire logic       dest_sel,
   input  wire logic [7:0] literal,
   input  wire logic [7:0] file_rdata,
   input  wire logic       wake,
   output logic [7:0]      acc,
   output logic            carry_flag,
   output logic            half_carry_flag,
   output logic            zero_flag,
   output logic            file_we,
   output logic [6:0]      file_waddr,
   output logic [7:0]      file_wdata,
   output logic [7:0]      port_a_direction,
   output logic [7:0]      port_b_direction,
   output logic [7:0]      port_c_direction,
   output logic            timeout_status,
   output logic            power_down_status,
   output logic            wdt_clear,
   output logic            osc_run
);

   // ==========================================================
   // Decode
   rsx_state_t state;
   wire        go        = exec_valid && (state == RSX_ST_RUN);
   wire        op_rot    = go && exec_op == RSX_OP_ROT_RIGHT;
   wire        op_lsub   = go && exec_op == RSX_OP_LIT_SUB;
   wire        op_rsub   = go && exec_op == RSX_OP_REG_SUB;
   wire        op_bsub   = go && exec_op == RSX_OP_REG_SUB_BRW;
   wire        op_swap   = go && exec_op == RSX_OP_NIB_SWAP;
   wire        op_xl     = go && exec_op == RSX_OP_XOR_LIT;
   wire        op_xr     = go && exec_op == RSX_OP_XOR_REG;
   wire        op_dir    = go && exec_op == RSX_OP_DIR_LOAD;
   wire        op_sleep  = go && exec_op == RSX_OP_SLEEP;
   wire        is_sub    = op_lsub || op_rsub || op_bsub;
   wire        lit_op    = op_lsub || op_xl;
   wire        file_op   = op_rot || op_rsub || op_bsub || op_swap || op_xr;

   // ==========================================================
   // Arithmetic
   wire [7:0]  minuend   = op_lsub ? literal : file_rdata;
   // Borrow in is the inverted carry for the borrow form only
   wire        bin       = op_bsub ? ~carry_flag : 1'b0;
   wire [8:0]  sub_full  = {1'b0, minuend} + {1'b0, ~acc} + {8'h00, ~bin};
   wire [4:0]  sub_low   = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, ~bin};
   wire [7:0]  rot_res   = {carry_flag, file_rdata[7:1]};
   wire [7:0]  swap_res  = {file_rdata[3:0], file_rdata[7:4]};
   wire [7:0]  xor_res   = acc ^ (op_xl ? literal : file_rdata);

   logic [7:0] result;
   always_comb begin
      case (1'b1)
         op_rot:        result = rot_res;
         is_sub:        result = sub_full[7:0];
         op_swap:       result = swap_res;
         op_xl, op_xr:  result = xor_res;
         default:       result = 8'h00;
      endcase
   end

   wire        res_zero  = (result == 8'h00);
   wire        z_upd     = is_sub || op_xl || op_xr;
   wire        to_acc    = lit_op || (file_op && dest_sel == RSX_DEST_ACC);
   wire        to_file   = file_op && dest_sel == RSX_DEST_FILE;

   assign file_we    = to_file;
   assign file_waddr = file_addr & RSX_MAX_FILE_ADDR;
   assign file_wdata = result;
   assign wdt_clear  = op_sleep;
   assign osc_run    = (state == RSX_ST_RUN);

   // ==========================================================
   // Accumulator and flags
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc             <= RSX_ACC_RESET;
         carry_flag      <= RSX_FLAG_RESET;
         half_carry_flag <= RSX_FLAG_RESET;
         zero_flag       <= RSX_FLAG_RESET;
      end else begin
         if (to_acc)
            acc <= result;
         if (op_rot)
            carry_flag <= file_rdata[0];
         else if (is_sub)
            carry_flag <= sub_full[8];
         if (is_sub)
            half_carry_flag <= sub_low[4];
         if (z_upd)
            zero_flag <= res_zero;
      end
   end

   // ==========================================================
   // Direction registers; other operands leave them alone
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         port_a_direction <= RSX_DIR_RESET;
         port_b_direction <= RSX_DIR_RESET;
         port_c_direction <= RSX_DIR_RESET;
      end else if (op_dir) begin
         if (literal[2:0] == RSX_DIR_SEL_A && literal[7:3] == 5'h00)
            port_a_direction <= acc;
         if (literal[2:0] == RSX_DIR_SEL_B && literal[7:3] == 5'h00)
            port_b_direction <= acc;
         if (literal[2:0] == RSX_DIR_SEL_C && literal[7:3] == 5'h00)
            port_c_direction <= acc;
      end
   end

   // ==========================================================
   // Sleep state and power status
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state             <= RSX_ST_RUN;
         timeout_status    <= RSX_TO_RESET;
         power_down_status <= RSX_PD_RESET;
      end else begin
         case (state)
            RSX_ST_RUN: begin
               if (op_sleep) begin
                  state             <= RSX_ST_SLEEP;
                  timeout_status    <= 1'b1;
                  power_down_status <= 1'b0;
               end
            end
            RSX_ST_SLEEP: begin
               if (wake)
                  state <= RSX_ST_RUN;
            end
            default: state <= RSX_ST_RUN;
         endcase
      end
   end

   // ==========================================================
   // Checks
   property p_rot;
      @(posedge clk) disable iff (!reset_n)
      op_rot |=> carry_flag == $past(file_rdata[0]) && half_carry_flag == $past(half_carry_flag);
   endproperty
   a_rot: assert property (p_rot) else $error("rotate carry wrong");

   property p_sub_c;
      @(posedge clk) disable iff (!reset_n)
      op_rsub |=> carry_flag == ($past(acc) <= $past(file_rdata));
   endproperty
   a_sub_c: assert property (p_sub_c) else $error("subtract carry wrong");

   property p_lsub;
      @(posedge clk) disable iff (!reset_n)
      op_lsub |=> acc == 8'($past(literal) - $past(acc))
         && half_carry_flag == ($past(acc[3:0]) <= $past(literal[3:0]));
   endproperty
   a_lsub: assert property (p_lsub) else $error("literal subtract wrong");

   property p_bsub;
      @(posedge clk) disable iff (!reset_n)
      (op_bsub && dest_sel == RSX_DEST_FILE) |->
         file_wdata == 8'(file_rdata - acc - {7'h00, ~carry_flag});
   endproperty
   a_bsub: assert property (p_bsub) else $error("borrow subtract wrong");

   property p_swap;
      @(posedge clk) disable iff (!reset_n)
      op_swap && dest_sel == RSX_DEST_ACC |=> acc == {$past(file_rdata[3:0]),
         $past(file_rdata[7:4])} && $stable(carry_flag) && $stable(zero_flag);
   endproperty
   a_swap: assert property (p_swap) else $error("swap wrong");

   property p_xl;
      @(posedge clk) disable iff (!reset_n)
      op_xl |=> acc == ($past(acc) ^ $past(literal)) && zero_flag == (acc == 8'h00)
         && $stable(carry_flag);
   endproperty
   a_xl: assert property (p_xl) else $error("xor literal wrong");

   property p_xr;
      @(posedge clk) disable iff (!reset_n)
      op_xr |-> !file_we == (dest_sel == RSX_DEST_ACC);
   endproperty
   a_xr: assert property (p_xr) else $error("xor destination wrong");

   property p_dir;
      @(posedge clk) disable iff (!reset_n)
      op_dir && literal == 8'h06 |=> port_b_direction == $past(acc)
         && $stable(port_a_direction);
   endproperty
   a_dir: assert property (p_dir) else $error("direction load wrong");

   sequence s_sleep_taken;
      op_sleep;
   endsequence
   property p_sleep;
      @(posedge clk) disable iff (!reset_n)
      s_sleep_taken |-> wdt_clear ##1 (timeout_status && !power_down_status && !osc_run);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep effects wrong");

   // ==========================================================
   // Flag and write-back checks
   property p_lsub_c;
      @(posedge clk) disable iff (!reset_n)
      op_lsub |=> carry_flag == ($past(acc) <= $past(literal)) && zero_flag == (acc == 8'h00);
   endproperty
   a_lsub_c: assert property (p_lsub_c) else $error("lsub carry wrong");

   property p_sub_dc;
      @(posedge clk) disable iff (!reset_n)
      op_rsub |=> half_carry_flag == ($past(acc[3:0]) <= $past(file_rdata[3:0]));
   endproperty
   a_sub_dc: assert property (p_sub_dc) else $error("sub half carry wrong");

   property p_sub_file;
      @(posedge clk) disable iff (!reset_n)
      (op_rsub && dest_sel == RSX_DEST_FILE) |-> file_we && file_wdata == 8'(file_rdata - acc);
   endproperty
   a_sub_file: assert property (p_sub_file) else $error("sub write wrong");

   property p_bsub_c;
      @(posedge clk) disable iff (!reset_n)
      op_bsub |=> carry_flag ==
         (({1'b0, $past(acc)} + {8'h00, !$past(carry_flag)}) <= {1'b0, $past(file_rdata)});
   endproperty
   a_bsub_c: assert property (p_bsub_c) else $error("borrow carry wrong");

   property p_xr_z;
      @(posedge clk) disable iff (!reset_n)
      op_xr |=> zero_flag == (($past(acc) ^ $past(file_rdata)) == 8'h00)
         && $stable(carry_flag) && $stable(half_carry_flag);
   endproperty
   a_xr_z: assert property (p_xr_z) else $error("xor register flags wrong");

   property p_rot_acc;
      @(posedge clk) disable iff (!reset_n)
      (op_rot && dest_sel == RSX_DEST_ACC) |=>
         acc == {$past(carry_flag), $past(file_rdata[7:1])} && $stable(zero_flag);
   endproperty
   a_rot_acc: assert property (p_rot_acc) else $error("rotate result wrong");

   property p_swap_file;
      @(posedge clk) disable iff (!reset_n)
      (op_swap && dest_sel == RSX_DEST_FILE) |-> file_we
         && file_wdata[7:4] == file_rdata[3:0] && file_wdata[3:0] == file_rdata[7:4];
   endproperty
   a_swap_file: assert property (p_swap_file) else $error("swap write wrong");

   // Out-of-range operands must leave every direction register alone
   property p_dir_keep;
      @(posedge clk) disable iff (!reset_n)
      (op_dir && (literal < 8'h05 || literal > 8'h07)) |=> $stable(port_a_direction)
         && $stable(port_b_direction) && $stable(port_c_direction);
   endproperty
   a_dir_keep: assert property (p_dir_keep) else $error("bad operand loaded");

   property p_dir_flags;
      @(posedge clk) disable iff (!reset_n)
      op_dir |=> $stable(acc) && $stable(carry_flag) && $stable(half_carry_flag)
         && $stable(zero_flag);
   endproperty
   a_dir_flags: assert property (p_dir_flags) else $error("load touched flags");

   sequence s_asleep_quiet;
      (!file_we && !wdt_clear) ##1 ($stable(acc) && $stable(zero_flag));
   endsequence
   property p_asleep;
      @(posedge clk) disable iff (!reset_n)
      !osc_run |-> s_asleep_quiet;
   endproperty
   a_asleep: assert property (p_asleep) else $error("sleeping core did work");

   property p_lit_no_file;
      @(posedge clk) disable iff (!reset_n)
      (op_lsub || op_xl) |-> !file_we;
   endproperty
   a_lit_no_file: assert property (p_lit_no_file) else $error("literal wrote file");

   property p_status_hold;
      @(posedge clk) disable iff (!reset_n)
      (osc_run && !op_sleep) |=> $stable(timeout_status) && $stable(power_down_status);
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("status changed");

endmodule // rsx_exec

/* tb/rsx_exec_tb.sv */
// Purpose: Self-checking bench for the rotate/subtract/xor/sleep unit
// Assumes: One instruction every other cycle; file read data driven by the bench
// Notes:   Expected values are worked out by hand from the instruction semantics
`timescale 1ns/1ps
module rsx_exec_tb;
   import rsx_pkg::*;
   logic       clk        = 1'b0;
   logic       reset_n    = 1'b0;
   logic       exec_valid = 1'b0;
   rsx_op_t    exec_op    = RSX_OP_NONE;
   logic [6:0] file_addr  = 7'h00;
   logic       dest_sel   = 1'b0;
   logic [7:0] literal    = 8'h00;
   logic [7:0] file_rdata = 8'h00;
   logic       wake       = 1'b0;
   logic [7:0] acc, file_wdata, dir_a, dir_b, dir_c, cur, wd_s;
   logic [6:0] file_waddr, wa_s;
   logic       c_f, dc_f, z_f, file_we, to_s, pd_s, wdt_clear, osc_run, we_s, wc_s;
   int         errors   = 0;
   int         n_checks = 0;
   int         i;

   always #4 clk = ~clk;

   rsx_exec dut_u (.clk(clk), .reset_n(reset_n), .exec_valid(exec_valid), .exec_op(exec_op),
      .file_addr(file_addr), .dest_sel(dest_sel), .literal(literal), .file_rdata(file_rdata),
      .wake(wake), .acc(acc), .carry_flag(c_f), .half_carry_flag(dc_f), .zero_flag(z_f),
      .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
      .port_a_direction(dir_a), .port_b_direction(dir_b), .port_c_direction(dir_c),
      .timeout_status(to_s), .power_down_status(pd_s), .wdt_clear(wdt_clear),
      .osc_run(osc_run));

   // ==========================================================
   // Bench tasks
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic give_verdict;
      if (errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Combinational outputs are caught mid-cycle, before the edge that retires the op
   task automatic run(rsx_op_t op, logic d, logic [7:0] lit, logic [7:0] fr);
      @(posedge clk);
      exec_valid <= 1'b1;
      exec_op    <= op;
      dest_sel   <= d;
      literal    <= lit;
      file_rdata <= fr;
      file_addr  <= 7'h7f;
      @(negedge clk);
      we_s = file_we;
      wd_s = file_wdata;
      wa_s = file_waddr;
      wc_s = wdt_clear;
      @(posedge clk);
      exec_valid <= 1'b0;
      file_rdata <= ~fr;
      @(negedge clk);
   endtask

   task automatic post(logic [7:0] ea, logic [2:0] ef);
      chk("acc", acc, ea);
      chk("flags c dc z", {5'h00, c_f, dc_f, z_f}, {5'h00, ef});
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      post(8'h00, 3'b000);
      chk("status", {6'h00, to_s, pd_s}, 8'h03);
      chk("dir b", dir_b, 8'hff);
      run(RSX_OP_XOR_LIT, 1'b0, 8'h3c, 8'h00); post(8'h3c, 3'b000);
      chk("wdt clear", {7'h00, wc_s}, 8'h00);
      run(RSX_OP_XOR_LIT, 1'b0, 8'h3c, 8'h00); post(8'h00, 3'b001);
      run(RSX_OP_XOR_LIT, 1'b1, 8'h03, 8'h00); post(8'h03, 3'b000);
      chk("we", {7'h00, we_s}, 8'h00);
      run(RSX_OP_REG_SUB, 1'b1, 8'h00, 8'h05); post(8'h03, 3'b110);
      chk("wdata", wd_s, 8'h02);
      chk("waddr", {1'b0, wa_s}, 8'h7f);
      chk("we", {7'h00, we_s}, 8'h01);
      run(RSX_OP_REG_SUB, 1'b0, 8'h00, 8'h02); post(8'hff, 3'b000);
      chk("we", {7'h00, we_s}, 8'h00);
      run(RSX_OP_REG_SUB_BRW, 1'b0, 8'h00, 8'h10); post(8'h10, 3'b000);
      run(RSX_OP_REG_SUB_BRW, 1'b1, 8'h00, 8'h11); post(8'h10, 3'b111);
      chk("wdata", wd_s, 8'h00);
      run(RSX_OP_ROT_RIGHT, 1'b0, 8'h00, 8'h02); post(8'h81, 3'b011);
      run(RSX_OP_ROT_RIGHT, 1'b1, 8'h00, 8'h01); post(8'h81, 3'b111);
      chk("wdata", wd_s, 8'h00);
      run(RSX_OP_NIB_SWAP, 1'b0, 8'h00, 8'ha5); post(8'h5a, 3'b111);
      run(RSX_OP_LIT_SUB, 1'b0, 8'h50, 8'h00); post(8'hf6, 3'b000);
      run(RSX_OP_XOR_REG, 1'b1, 8'h00, 8'hf6); post(8'hf6, 3'b001);
      chk("wdata", wd_s, 8'h00);
      cur = 8'hf6;
      for (i = 4; i < 8; i++) begin
         run(RSX_OP_XOR_LIT, 1'b0, cur ^ 8'(i << 4), 8'h00);
         cur = 8'(i << 4);
         run(RSX_OP_DIR_LOAD, 1'b0, 8'(i), 8'h00);
         if (i == 4) begin
            chk("dir a", dir_a, 8'hff);
            chk("dir c", dir_c, 8'hff);
         end
      end
      chk("dir a", dir_a, 8'h50);
      chk("dir b", dir_b, 8'h60);
      chk("dir c", dir_c, 8'h70);
      // Low bits select A but the upper bits make the operand illegal
      run(RSX_OP_DIR_LOAD, 1'b0, 8'h0d, 8'h00); chk("dir a", dir_a, 8'h50);
      run(RSX_OP_SLEEP, 1'b0, 8'h00, 8'h00);
      chk("wdt clear", {7'h00, wc_s}, 8'h01);
      chk("status", {6'h00, to_s, pd_s}, 8'h02);
      chk("osc", {7'h00, osc_run}, 8'h00);
      // Sleeping core must ignore work
      run(RSX_OP_XOR_LIT, 1'b0, 8'hff, 8'h00); chk("acc", acc, 8'h70);
      @(posedge clk);
      wake <= 1'b1;
      for (i = 0; i < 4 && osc_run !== 1'b1; i++) @(negedge clk);
      @(posedge clk);
      wake <= 1'b0;
      chk("osc after wake", {7'h00, osc_run}, 8'h01);
      if (osc_run === 1'b1) begin
         run(RSX_OP_XOR_LIT, 1'b0, 8'hff, 8'h00); chk("acc", acc, 8'h8f);
      end
      give_verdict();
   end
endmodule // rsx_exec_tb
